// >>> design/dpt_host_ctrl.sv
// Host controller that sequences a two-channel PWM timer through its register port
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module dpt_host_ctrl
   import dpt_pkg::*;
(
   // Clock and reset
   input logic aclk,
   input logic aresetn,
   // AXI4-Lite write channels
   input logic [7:0] s_axi_awaddr,
   input logic s_axi_awvalid,
   output logic s_axi_awready,
   input logic [31:0] s_axi_wdata,
   input logic [3:0] s_axi_wstrb,
   input logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input logic s_axi_bready,
   // AXI4-Lite read channels
   input logic [7:0] s_axi_araddr,
   input logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input logic s_axi_rready,
   // Timer register port
   output logic [7:0] dev_addr,
   output logic [15:0] dev_wdata,
   output logic dev_wr,
   output logic dev_rd,
   input logic [15:0] dev_rdata,
   // Oscillator and supply
   output logic fast_osc_enable,
   input logic supply_ok,
   // Timer I/O pin used for capture
   input logic cap_pin_i,
   output logic cap_pin_o,
   output logic cap_pin_oe
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   function automatic logic [2:0] buf_mask_of(input logic [7:0] a);
      return (a == DEV_GRD0) ? BUF_D0 : (a == DEV_GRC1) ? BUF_C1 : (a == DEV_GRD1) ? BUF_D1 : 3'h0;
   endfunction

   // Pin synchronisers
   logic supply_s1_reg, supply_s;
   logic cap_s1_reg, cap_s;
   logic [15:0] rdata_s1_reg, rdata_s;
   always_ff @(posedge aclk) begin
      supply_s1_reg <= supply_ok;
      supply_s <= supply_s1_reg;
      cap_s1_reg <= cap_pin_i;
      cap_s <= cap_s1_reg;
      rdata_s1_reg <= dev_rdata;
      rdata_s <= rdata_s1_reg;
   end

   // AXI4-Lite slave
   logic aw_got_reg, w_got_reg, bvalid_reg, rvalid_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg, rdata_reg;
   logic [3:0] w_strb_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [15:0] cmd_reg, data_reg, rd_val_reg;
   wire aw_fire = s_axi_awvalid && s_axi_awready;
   wire w_fire = s_axi_wvalid && s_axi_wready;
   wire ar_fire = s_axi_arvalid && s_axi_arready;
   wire wr_go = aw_got_reg && w_got_reg;
   wire wr_cmd = wr_go && aw_addr_reg == ADDR_CMD;
   wire wr_data = wr_go && aw_addr_reg == ADDR_DATA;
   wire wr_mapped = wr_cmd || wr_data || aw_addr_reg == ADDR_STATUS || aw_addr_reg == ADDR_RDATA;
   wire cmd_go = wr_cmd && w_strb_reg[1:0] == 2'b11;
   wire rd_mapped = s_axi_araddr == ADDR_CMD || s_axi_araddr == ADDR_DATA ||
      s_axi_araddr == ADDR_STATUS || s_axi_araddr == ADDR_RDATA;
   assign s_axi_awready = !aw_got_reg && !bvalid_reg;
   assign s_axi_wready = !w_got_reg && !bvalid_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // Controller state
   dpt_state_e state_reg, state_next;
   logic [7:0] cnt_reg, cnt_next;
   logic [1:0] step_reg;
   logic [3:0] op_reg, arg_reg;
   logic [7:0] addr_reg;
   logic [15:0] pay_reg;
   logic [3:0] start_sh, fcr_sh;
   logic [2:0] buf_sh;
   logic refused_reg, rd_done_reg, fast_osc_reg;
   logic dev_wr_reg, dev_rd_reg;
   logic [7:0] dev_addr_reg;
   logic [15:0] dev_wdata_reg;
   logic cap_busy;
   wire busy = state_reg != ST_IDLE;

   wire [31:0] status_word = {15'h0000, buf_sh, fcr_sh, start_sh, cap_s, supply_s, fast_osc_reg,
      rd_done_reg, refused_reg, busy};
   wire [31:0] rd_mux = (s_axi_araddr == ADDR_CMD) ? {16'h0000, cmd_reg} :
      (s_axi_araddr == ADDR_DATA) ? {16'h0000, data_reg} :
      (s_axi_araddr == ADDR_STATUS) ? status_word :
      (s_axi_araddr == ADDR_RDATA) ? {16'h0000, rd_val_reg} : 32'h00000000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         bresp_reg <= RESP_OKAY;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= 32'h00000000;
      end else begin
         if (aw_fire) begin
            aw_got_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_got_reg <= 1'b0;
         end
         if (w_fire) begin
            w_got_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end else if (wr_go) begin
            w_got_reg <= 1'b0;
         end
         if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
         if (ar_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // Command checks
   wire [3:0] c_op = w_data_reg[CMD_OP_LSB +: 4];
   wire [7:0] c_addr = w_data_reg[CMD_ADDR_LSB +: 8];
   wire c_comp = fcr_sh[1];
   wire c_active = c_addr == DEV_GRA0 || c_addr == DEV_GRB0 || c_addr == DEV_GRA1 || c_addr == DEV_GRB1;
   wire c_cfg = c_addr == DEV_FCR || c_addr == DEV_BUFMODE || c_addr == DEV_CTRL0 || c_addr == DEV_CTRL1;
   wire c_fast = data_reg[CTRL_SRC_LSB +: 3] == SRC_FAST;
   wire c_bad = (c_op == OP_WRITE && ((c_comp && c_active) || c_cfg)) ||
      (c_op == OP_SOURCE && c_fast && !supply_s) ||
      (c_op == OP_WRITE && (buf_mask_of(c_addr) & buf_sh) != 3'h0) ||
      (c_op == OP_BUFFER && buf_mask_of(c_addr) == 3'h0) || c_op == 4'h0 || c_op > OP_CAPTURE;
   wire accept = cmd_go && state_reg == ST_IDLE && !c_bad;
   wire refuse = cmd_go && !accept;
   wire [2:0] buf_mask = buf_mask_of(addr_reg);
   wire osc_off_req = op_reg == OP_SOURCE && arg_reg[1] && pay_reg[CTRL_SRC_LSB +: 3] != SRC_FAST;

   // Write sequence for the current step
   logic [7:0] st_addr;
   logic [15:0] st_data;
   logic [2:0] st_num;
   always_comb begin
      st_addr = DEV_START;
      st_data = STOP_VAL;
      st_num = 3'd2;
      unique case (op_reg)
         OP_WRITE: begin
            st_num = 3'd1;
            st_addr = addr_reg;
            st_data = pay_reg;
         end
         OP_START: begin
            st_num = 3'd1;
            st_data = {12'h000, pay_reg[3:0]};
         end
         OP_MODE: begin
            st_num = 3'd4;
            if (step_reg[1]) begin
               st_addr = DEV_FCR;
               st_data = {12'h000, arg_reg[2], arg_reg[2], step_reg[0] ? arg_reg[1:0] : MODE_TIMER};
            end
         end
         OP_SOURCE: begin
            st_num = 3'd3;
            if (step_reg == 2'd2) begin
               st_addr = arg_reg[0] ? DEV_CTRL1 : DEV_CTRL0;
               st_data = pay_reg;
            end
         end
         OP_BUFFER: begin
            st_num = 3'd3;
            unique case (step_reg)
               2'd0: begin
                  st_addr = DEV_BUFMODE;
                  st_data = {13'h0000, buf_sh & ~buf_mask};
               end
               2'd1: begin
                  st_addr = addr_reg;
                  st_data = pay_reg;
               end
               default: begin
                  st_addr = DEV_BUFMODE;
                  st_data = {13'h0000, buf_sh | buf_mask};
               end
            endcase
         end
         default: ;
      endcase
   end
   wire last_step = {1'b0, step_reg} == st_num - 3'd1;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: if (accept) state_next = (c_op == OP_READ) ? ST_READ : (c_op == OP_CAPTURE) ? ST_CAPT : ST_WRITE;
         ST_WRITE: state_next = ST_GAP;
         ST_GAP: if (cnt_reg == 8'(GAP_CYC - 1)) state_next = !last_step ? ST_WRITE : osc_off_req ? ST_OSCW : ST_IDLE;
         ST_READ: if (cnt_reg == 8'(RD_CYC - 1)) state_next = ST_IDLE;
         ST_OSCW: if (cnt_reg == 8'(OSC_WAIT_CYC - 1)) state_next = ST_IDLE;
         ST_CAPT: if (cnt_reg != 8'h00 && !cap_busy) state_next = ST_IDLE;
      endcase
   end
   assign cnt_next = (state_next != state_reg) ? 8'h00 : cnt_reg + 8'h01;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 8'h00;
         step_reg <= 2'd0;
         op_reg <= 4'h0;
         arg_reg <= 4'h0;
         addr_reg <= 8'h00;
         pay_reg <= 16'h0000;
         cmd_reg <= 16'h0000;
         data_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         if (wr_data && w_strb_reg[0]) data_reg[7:0] <= w_data_reg[7:0];
         if (wr_data && w_strb_reg[1]) data_reg[15:8] <= w_data_reg[15:8];
         if (cmd_go) cmd_reg <= w_data_reg[15:0];
         if (accept) begin
            op_reg <= c_op;
            arg_reg <= w_data_reg[CMD_ARG_LSB +: 4];
            addr_reg <= c_addr;
            pay_reg <= data_reg;
            step_reg <= 2'd0;
         end else if (state_reg == ST_GAP && state_next == ST_WRITE) begin
            step_reg <= step_reg + 2'd1;
         end
      end
   end

   // Register port drive, shadows and status
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dev_wr_reg <= 1'b0;
         dev_rd_reg <= 1'b0;
         dev_addr_reg <= 8'h00;
         dev_wdata_reg <= 16'h0000;
         start_sh <= 4'h0;
         fcr_sh <= 4'h0;
         buf_sh <= 3'h0;
         refused_reg <= 1'b0;
         rd_done_reg <= 1'b0;
         rd_val_reg <= 16'h0000;
         fast_osc_reg <= 1'b0;
      end else begin
         dev_wr_reg <= state_reg == ST_WRITE;
         dev_rd_reg <= state_reg == ST_READ;
         if (state_reg == ST_WRITE) begin
            dev_addr_reg <= st_addr;
            dev_wdata_reg <= st_data;
         end else if (accept) begin
            dev_addr_reg <= c_addr;
         end
         if (dev_wr_reg && dev_addr_reg == DEV_START) start_sh <= dev_wdata_reg[3:0];
         if (dev_wr_reg && dev_addr_reg == DEV_FCR) fcr_sh <= dev_wdata_reg[3:0];
         if (dev_wr_reg && dev_addr_reg == DEV_BUFMODE) buf_sh <= dev_wdata_reg[2:0];
         if (refuse) refused_reg <= 1'b1;
         else if (accept) refused_reg <= 1'b0;
         if (state_reg == ST_READ && state_next == ST_IDLE) begin
            rd_done_reg <= 1'b1;
            rd_val_reg <= rdata_s;
         end else if (accept) begin
            rd_done_reg <= 1'b0;
         end
         if (accept && c_op == OP_SOURCE && c_fast) fast_osc_reg <= 1'b1;
         else if (state_reg == ST_OSCW && state_next == ST_IDLE) fast_osc_reg <= 1'b0;
      end
   end

   assign dev_wr = dev_wr_reg;
   assign dev_rd = dev_rd_reg;
   assign dev_addr = dev_addr_reg;
   assign dev_wdata = dev_wdata_reg;
   assign fast_osc_enable = fast_osc_reg;

   dpt_capture_pulse u_capture (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(state_reg == ST_CAPT && cnt_reg == 8'h00),
      .busy(cap_busy),
      .pin_o(cap_pin_o),
      .pin_oe(cap_pin_oe)
   );

   // Checks on what the register port issues
   logic [7:0] since_ctrl_reg;
   wire dw_ctrl = dev_wr_reg && (dev_addr_reg == DEV_CTRL0 || dev_addr_reg == DEV_CTRL1);
   wire dw_fcr = dev_wr_reg && dev_addr_reg == DEV_FCR;
   wire dw_active = dev_addr_reg == DEV_GRA0 || dev_addr_reg == DEV_GRB0 ||
      dev_addr_reg == DEV_GRA1 || dev_addr_reg == DEV_GRB1;
   always_ff @(posedge aclk) begin
      if (!aresetn) since_ctrl_reg <= 8'hff;
      else if (dw_ctrl) since_ctrl_reg <= 8'h00;
      else if (since_ctrl_reg != 8'hff) since_ctrl_reg <= since_ctrl_reg + 8'h01;
   end
   sequence s_dev_write;
      dev_wr_reg;
   endsequence
   sequence s_idle_port;
      !dev_wr_reg && !dev_rd_reg;
   endsequence

   a_start_whole_write: assert property (dev_wr_reg && dev_addr_reg == DEV_START |-> dev_wdata_reg[15:4] == 12'h000)
      else $error("start control write not a clean whole-register value");
   a_write_read_gap: assert property (s_dev_write |=> s_idle_port)
      else $error("register access right after a write");
   a_source_when_stopped: assert property (dw_ctrl |-> start_sh[1:0] == 2'b00 && start_sh[3:2] == 2'b11)
      else $error("count source written while a channel may run");
   a_osc_stop_wait: assert property ($fell(fast_osc_reg) |-> since_ctrl_reg >= 8'(OSC_WAIT_CYC))
      else $error("fast oscillator stopped too soon after source switch");
   a_mode_via_timer: assert property (dw_fcr && dev_wdata_reg[1:0] != MODE_TIMER |-> fcr_sh[1:0] == MODE_TIMER)
      else $error("combination mode entered without passing through 00b");
   a_mode_change_stopped: assert property (dw_fcr |-> start_sh[1:0] == 2'b00)
      else $error("combination mode changed while counting");
   a_output_levels_equal: assert property (dw_fcr |-> dev_wdata_reg[FCR_OLS_POS] == dev_wdata_reg[FCR_OLS_NEG])
      else $error("output level selects differ");
   a_no_active_compare: assert property (dev_wr_reg && fcr_sh[1] |-> !dw_active)
      else $error("active compare register written in complementary mode");
   a_buffer_load_order: assert property (dev_wr_reg && buf_mask_of(dev_addr_reg) != 3'h0 |->
      (buf_sh & buf_mask_of(dev_addr_reg)) == 3'h0 ##3 s_dev_write)
      else $error("buffer loaded while its buffer enable was set");
   a_fast_source_osc: assert property (dw_ctrl && dev_wdata_reg[CTRL_SRC_LSB +: 3] == SRC_FAST |-> fast_osc_reg)
      else $error("fast source selected without an accepted supply check");
endmodule

// >>> design/dpt_pkg.sv
// Constants, register maps and state encodings for the PWM timer host controller
package dpt_pkg;
   // Own AXI4-Lite register byte offsets
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_DATA = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_RDATA = 8'h0c;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Command word fields
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_ARG_LSB = 4;
   localparam int CMD_ADDR_LSB = 8;
   // Command codes
   localparam logic [3:0] OP_WRITE = 4'h1;
   localparam logic [3:0] OP_READ = 4'h2;
   localparam logic [3:0] OP_START = 4'h3;
   localparam logic [3:0] OP_STOP = 4'h4;
   localparam logic [3:0] OP_MODE = 4'h5;
   localparam logic [3:0] OP_SOURCE = 4'h6;
   localparam logic [3:0] OP_BUFFER = 4'h7;
   localparam logic [3:0] OP_CAPTURE = 4'h8;
   // Timer register indices on the device register port
   localparam logic [7:0] DEV_START = 8'h00;
   localparam logic [7:0] DEV_FCR = 8'h01;
   localparam logic [7:0] DEV_BUFMODE = 8'h02;
   localparam logic [7:0] DEV_CTRL0 = 8'h03;
   localparam logic [7:0] DEV_CTRL1 = 8'h04;
   localparam logic [7:0] DEV_STATUS0 = 8'h05;
   localparam logic [7:0] DEV_STATUS1 = 8'h06;
   localparam logic [7:0] DEV_CNT0 = 8'h07;
   localparam logic [7:0] DEV_CNT1 = 8'h08;
   localparam logic [7:0] DEV_GRA0 = 8'h09;
   localparam logic [7:0] DEV_GRB0 = 8'h0a;
   localparam logic [7:0] DEV_GRC0 = 8'h0b;
   localparam logic [7:0] DEV_GRD0 = 8'h0c;
   localparam logic [7:0] DEV_GRA1 = 8'h0d;
   localparam logic [7:0] DEV_GRB1 = 8'h0e;
   localparam logic [7:0] DEV_GRC1 = 8'h0f;
   localparam logic [7:0] DEV_GRD1 = 8'h10;
   // Device register fields
   localparam logic [15:0] STOP_VAL = 16'h000c;
   localparam int FCR_OLS_POS = 2;
   localparam int FCR_OLS_NEG = 3;
   localparam int CTRL_SRC_LSB = 0;
   localparam logic [2:0] SRC_FAST = 3'h6;
   localparam logic [1:0] MODE_TIMER = 2'h0;
   localparam logic [2:0] BUF_D0 = 3'h1;
   localparam logic [2:0] BUF_C1 = 3'h2;
   localparam logic [2:0] BUF_D1 = 3'h4;
   // Timing
   localparam int CLK_NS = 20;
   localparam int GAP_CYC = 2;
   localparam int RD_CYC = 5;
   localparam int F1_PERIOD_NS = 50;
   localparam int OSC_WAIT_F1 = 2;
   localparam int OSC_WAIT_CYC = (OSC_WAIT_F1 * F1_PERIOD_NS + CLK_NS - 1) / CLK_NS;
   localparam int OPCLK_PERIOD_NS = 50;
   localparam int CAP_OPCLK = 3;
   localparam int CAP_CYC = (CAP_OPCLK * OPCLK_PERIOD_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_WRITE = 6'b000010,
      ST_GAP = 6'b000100,
      ST_READ = 6'b001000,
      ST_OSCW = 6'b010000,
      ST_CAPT = 6'b100000
   } dpt_state_e;
endpackage

// >>> design/dpt_capture_pulse.sv
// Capture pulse driver for one timer I/O pin
`timescale 1ns/1ps
module dpt_capture_pulse
   import dpt_pkg::*;
(
   // Clock and reset
   input logic aclk,
   input logic aresetn,
   // Trigger
   input logic start,
   output logic busy,
   // Pin drive
   output logic pin_o,
   output logic pin_oe
);
   logic pin_reg;
   logic pin_next;
   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;

   // Pulse stays high for the full capture width
   assign pin_next = start ? 1'b1 : (pin_reg && cnt_reg != 8'(CAP_CYC - 1));
   assign cnt_next = pin_reg ? cnt_reg + 8'h01 : 8'h00;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_reg <= 1'b0;
         cnt_reg <= 8'h00;
      end else begin
         pin_reg <= pin_next;
         cnt_reg <= cnt_next;
      end
   end

   assign busy = pin_reg;
   assign pin_o = pin_reg;
   assign pin_oe = pin_reg;

   a_capture_width: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(pin_reg) |-> pin_reg [*8])
      else $error("capture pulse shorter than minimum width");
endmodule

// >>> tb/dpt_dev_model.sv
// Behavioural model of the two-channel timer register port
`timescale 1ns/1ps
module dpt_dev_model
   import dpt_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register port
   input wire logic [7:0] dev_addr,
   input wire logic [15:0] dev_wdata,
   input wire logic dev_wr,
   input wire logic dev_rd,
   output logic [15:0] dev_rdata,
   // Sequencing faults seen
   output logic [7:0] viol_count
);
   logic [15:0] regs [0:16];
   logic [15:0] last_rd;
   logic flag_armed;
   wire logic [4:0] idx = dev_addr[4:0];
   wire logic run_any = |regs[0][1:0];
   wire logic bad_fcr = run_any || (regs[1][1:0] != MODE_TIMER && dev_wdata[1:0] != MODE_TIMER);
   wire logic [2:0] buf_hit = {dev_addr == DEV_GRD1, dev_addr == DEV_GRC1, dev_addr == DEV_GRD0};
   wire logic bad_gr = (regs[1][1] && run_any && dev_addr inside {DEV_GRA0, DEV_GRB0, DEV_GRA1, DEV_GRB1})
      || (buf_hit & regs[2][2:0]) != 3'h0;
   // Channel 0 clear event chosen by the clear select field in bits 5:3 of its control register
   wire logic [2:0] clr_sel = regs[3][5:3];
   wire logic clr0 = (clr_sel == 3'b001 && regs[7] == regs[9]) || (clr_sel == 3'b010 && regs[7] == regs[10]) ||
      (clr_sel == 3'b101 && regs[7] == regs[11]) || (clr_sel == 3'b110 && regs[7] == regs[12]);
   // Released read bus shows the inverse of the last value
   assign dev_rdata = dev_rd ? regs[idx] : ~last_rd;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 17; i++) regs[i] <= 16'h0000;
         regs[5] <= 16'h0001;
         last_rd <= 16'h0000;
         flag_armed <= 1'b0;
         viol_count <= 8'h00;
      end else begin
         if (regs[0][0]) regs[7] <= regs[7] + 16'h0001;
         if (dev_rd) begin
            last_rd <= regs[idx];
            if (dev_addr == DEV_STATUS0 && regs[5][0]) flag_armed <= 1'b1;
         end
         if (dev_wr && dev_addr <= DEV_GRD1) begin
            case (dev_addr)
               DEV_START: regs[0] <= {dev_wdata[15:2], dev_wdata[1:0] | (regs[0][1:0] & ~regs[0][3:2])};
               DEV_STATUS0: begin
                  regs[5][0] <= regs[5][0] & ~(flag_armed & ~dev_wdata[0]);
                  flag_armed <= 1'b0;
               end
               DEV_FCR: begin
                  if (bad_fcr) viol_count <= viol_count + 8'h01;
                  regs[1] <= dev_wdata;
               end
               DEV_CTRL0, DEV_CTRL1: begin
                  if (run_any) viol_count <= viol_count + 8'h01;
                  regs[idx] <= dev_wdata;
               end
               default: begin
                  if (bad_gr) viol_count <= viol_count + 8'h01;
                  regs[idx] <= dev_wdata;
               end
            endcase
         end
         // A clear coinciding with a counter write wins
         if (regs[0][0] && clr0) regs[7] <= 16'h0000;
      end
   end
endmodule

// >>> tb/tb_dpt_host_ctrl.sv
// Self-checking bench for the PWM timer host controller
`timescale 1ns/1ps
module tb_dpt_host_ctrl;
   import dpt_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, supply_ok = 1'b1, osc_d = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, dev_addr, viol_count;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, dev_wr, dev_rd, fast_osc_enable, cap_pin_o, cap_pin_oe;
   logic [15:0] dev_wdata, dev_rdata;
   int err_count = 0, total_checks = 0, cyc = 0, ctrl_age = 0, osc_gap = 0, cap_run = 0, cap_w = 0;
   // Capture pin is pulled low when not driven
   wire logic cap_pin = cap_pin_oe ? cap_pin_o : 1'b0;
   dpt_host_ctrl u_dpt_host_ctrl (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd),
      .dev_rdata(dev_rdata), .fast_osc_enable(fast_osc_enable), .supply_ok(supply_ok),
      .cap_pin_i(cap_pin), .cap_pin_o(cap_pin_o), .cap_pin_oe(cap_pin_oe));
   dpt_dev_model u_dpt_dev_model (.aclk(aclk), .aresetn(aresetn), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
      .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata), .viol_count(viol_count));
   always #10 aclk = ~aclk;
   // Measures pulse width and the oscillator hold-off after a source switch
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      ctrl_age <= (dev_wr && dev_addr == DEV_CTRL0) ? 0 : ctrl_age + 1;
      cap_run <= cap_pin_o ? cap_run + 1 : 0;
      if (!cap_pin_o && cap_run != 0) cap_w <= cap_run;
      if (osc_d && !fast_osc_enable) osc_gap <= ctrl_age;
      osc_d <= fast_osc_enable;
      if (cyc == 20000) begin
         err_count++;
         results();
      end
   end
   task automatic results();
      $display("checks=%0d errors=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         aw_ok = aw_ok | awready;
         w_ok = w_ok | wready;
         awvalid <= !aw_ok;
         wvalid <= !w_ok;
      end
      do @(posedge aclk); while (!bvalid);
      r = bresp;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
   endtask
   task automatic cmd(input logic [3:0] op, input logic [3:0] arg, input logic [7:0] ix, input logic [15:0] d);
      logic [1:0] r;
      logic [31:0] s;
      int n;
      n = 0;
      axi_wr(ADDR_DATA, {16'h0000, d}, r);
      axi_wr(ADDR_CMD, {16'h0000, ix, arg, op}, r);
      repeat (3) @(posedge aclk);
      do begin
         axi_rd(ADDR_STATUS, s, r);
         n++;
      end while (s[0] && n < 100);
      chk({15'h0, s[0]}, 16'h0000);
   endtask
   task automatic t_regs();
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(ADDR_STATUS, d, r);
      chk(d[15:0], 16'h0010);
      axi_wr(8'h10, 32'h1, r);
      chk({14'h0, r}, {14'h0, RESP_SLVERR});
      axi_rd(8'h14, d, r);
      chk({14'h0, r}, {14'h0, RESP_SLVERR});
   endtask
   task automatic t_startstop();
      cmd(OP_START, 4'h0, 8'h00, 16'h0003);
      chk(u_dpt_dev_model.regs[0], 16'h0003);
      cmd(OP_STOP, 4'h0, 8'h00, 16'h0000);
      chk(u_dpt_dev_model.regs[0], STOP_VAL);
   endtask
   task automatic t_mode();
      logic [31:0] d;
      logic [1:0] r;
      for (int m = 1; m < 4; m++) begin
         cmd(OP_MODE, {2'b01, 2'(m)}, 8'h00, 16'h0000);
         chk(u_dpt_dev_model.regs[1], 16'h000c | 16'(m));
      end
      cmd(OP_WRITE, 4'h0, DEV_GRA0, 16'h0100);
      axi_rd(ADDR_STATUS, d, r);
      chk({15'h0, d[1]}, 16'h0001);
      cmd(OP_MODE, 4'h4, 8'h00, 16'h0000);
      chk(u_dpt_dev_model.regs[1], 16'h000c);
      chk({8'h00, viol_count}, 16'h0000);
   endtask
   task automatic t_buffer();
      logic [7:0] ix [3] = '{DEV_GRD0, DEV_GRC1, DEV_GRD1};
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < 3; i++) begin
         cmd(OP_BUFFER, 4'h0, ix[i], 16'h1230 + 16'(i));
         chk(u_dpt_dev_model.regs[ix[i][4:0]], 16'h1230 + 16'(i));
         chk(u_dpt_dev_model.regs[2], 16'((2 << i) - 1));
      end
      cmd(OP_WRITE, 4'h0, DEV_GRD0, 16'h0055);
      axi_rd(ADDR_STATUS, d, r);
      chk({12'h0, d[16:14], d[1]}, 16'h000f);
      chk(u_dpt_dev_model.regs[ix[0][4:0]], 16'h1230);
      chk({8'h00, viol_count}, 16'h0000);
   endtask
   task automatic t_source();
      logic [31:0] d;
      logic [1:0] r;
      supply_ok <= 1'b0;
      repeat (4) @(posedge aclk);
      cmd(OP_SOURCE, 4'h0, 8'h00, {13'h0, SRC_FAST});
      axi_rd(ADDR_STATUS, d, r);
      chk({14'h0, d[3], d[1]}, 16'h0001);
      supply_ok <= 1'b1;
      repeat (4) @(posedge aclk);
      cmd(OP_SOURCE, 4'h0, 8'h00, {13'h0, SRC_FAST});
      chk({15'h0, fast_osc_enable}, 16'h0001);
      chk(u_dpt_dev_model.regs[3], {13'h0, SRC_FAST});
      cmd(OP_SOURCE, 4'h2, 8'h00, 16'h0001);
      repeat (OSC_WAIT_CYC + 4) @(posedge aclk);
      chk({15'h0, fast_osc_enable}, 16'h0000);
      chk({15'h0, osc_gap >= OSC_WAIT_CYC}, 16'h0001);
      cmd(OP_SOURCE, 4'h1, 8'h00, 16'h0002);
      chk(u_dpt_dev_model.regs[4], 16'h0002);
      chk({8'h00, viol_count}, 16'h0000);
   endtask
   task automatic t_capture();
      cmd(OP_CAPTURE, 4'h0, 8'h00, 16'h0000);
      repeat (4) @(posedge aclk);
      chk(16'(cap_w), 16'(CAP_CYC));
   endtask
   task automatic t_read();
      logic [31:0] d;
      logic [1:0] r;
      cmd(OP_WRITE, 4'h0, DEV_CNT0, 16'hbeef);
      cmd(OP_READ, 4'h0, DEV_CNT0, 16'h0000);
      axi_rd(ADDR_RDATA, d, r);
      chk(d[15:0], 16'hbeef);
      axi_rd(ADDR_STATUS, d, r);
      chk({15'h0, d[2]}, 16'h0001);
      cmd(OP_READ, 4'h0, DEV_STATUS0, 16'h0000);
      axi_rd(ADDR_RDATA, d, r);
      chk(d[15:0], 16'h0001);
      cmd(OP_WRITE, 4'h0, DEV_STATUS0, 16'h0000);
      cmd(OP_READ, 4'h0, DEV_STATUS0, 16'h0000);
      axi_rd(ADDR_RDATA, d, r);
      chk(d[15:0], 16'h0000);
   endtask
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs();
      t_startstop();
      t_mode();
      t_buffer();
      t_source();
      t_capture();
      t_read();
      results();
   end
endmodule
